// ---- verilog/cdvs_defines.svh ----
// offsets, field positions, reset values and timing counts of the card detect block
`ifndef CDVS_DEFINES_SVH
`define CDVS_DEFINES_SVH
`define CDVS_GENCTRL_OFFSET 8'h86
`define CDVS_GENCTRL_RESET  16'h0000
`define CDVS_PSWSEL_BIT     10
`define CDVS_CLK_NS         100
`define CDVS_SETTLE_NS      2000
`define CDVS_SYNC_LAT       4
`define CDVS_SETTLE_CYC     ((`CDVS_SETTLE_NS + `CDVS_CLK_NS - 1) / `CDVS_CLK_NS)
`endif

// ---- verilog/cdvs_pkg.sv ----
// types shared by the card detect and voltage sense logic
`default_nettype none
package cdvs_pkg;
  typedef enum logic [1:0] {SENSE_OPEN, SENSE_GND, SENSE_CD1, SENSE_CD2} cdvs_sense_type;
  typedef enum logic [2:0] {CARD_NONE, CARD_16BIT, CARD_CARDBUS, CARD_CUSTOM,
                            CARD_RESERVED} cdvs_card_type;
  typedef struct packed {
    logic           cd2Gnd;
    logic           cd1Gnd;
    cdvs_sense_type vs2;
    cdvs_sense_type vs1;
  } cdvs_wiring_type;
  typedef struct packed {
    cdvs_card_type kind;
    logic          needs5v;
    logic          needs3v;
    logic          needsXv;
    logic          needsYv;
    logic          core18;
  } cdvs_class_type;
  typedef struct packed {
    logic          cardPresent;
    cdvs_card_type kind;
    logic          lowVoltCardFlag;
    logic          altVoltCardFlag;
    logic          yVoltCardFlag;
    logic          fiveVoltCardFlag;
    logic          core18Card;
    logic          powerAllowed;
    logic          interrogating;
  } cdvs_present_type;
endpackage
`default_nettype wire

// ---- verilog/cdvs_pin_sync.sv ----
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cdvs_pin_sync
  import cdvs_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // pins and clean levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinStable
);
  initial
  begin
    if (WIDTH < 1)
      $error("cdvs_pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  always_comb
  begin
    stable_next = stable_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2_reg[i] == stage3_reg[i])
        stable_next[i] = stage3_reg[i];
    end
  end

  // lines idle high through the socket pullups
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      stage1_reg <= '1;
      stage2_reg <= '1;
      stage3_reg <= '1;
      stable_reg <= '1;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      stable_reg <= stable_next;
    end
  end

  assign pinStable = stable_reg;
endmodule
`default_nettype wire

// ---- verilog/cdvs_top.sv ----
// card detect and voltage sense interrogation with socket present state reporting
//
// Overview of operation
// - a card entering an unpowered socket starts interrogation before any power is allowed.
// - interrogation yields both the supply voltages and the 16-bit or CardBus interface type.
// - recognition uses only the two detect lines and the two voltage sense lines.
// - both detect lines grounded is a 16-bit card, a detect tied to a sense is CardBus or other.
// - detect2 tied to sense2, detect1 grounded, sense1 open decodes as 3.3 V CardBus, 1.8 V core.
// - low-voltage CardBus cards with 3.3 V supply and 1.8 V core are recognised.
// - with switch type select 0 a 1.8 V CardBus card sets the low-voltage card flag.
// - with switch type select 1 a 1.8 V CardBus card sets the alternate-voltage flag instead.
// - custom adapter cards are recognised from their tie pattern alone.
// - the switch type select bit resets to 0, the first switch control scheme.
`timescale 1ns/1ps
`default_nettype none
`include "cdvs_defines.svh"
module cdvs_top
  import cdvs_pkg::*;
#(
  parameter int SETTLE_CYCLES = `CDVS_SETTLE_CYC
)
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // socket detect and sense pins
  input  wire logic             cd1In,
  input  wire logic             cd2In,
  input  wire logic             vs1In,
  input  wire logic             vs2In,
  output logic                  cd1Out,
  output logic                  cd1OeB,
  output logic                  cd2Out,
  output logic                  cd2OeB,
  // socket power status
  input  wire logic             socketPowered,
  // configuration access
  input  wire logic [7:0]       cfgAddr,
  input  wire logic             cfgWrEn,
  input  wire logic [15:0]      cfgWrData,
  output logic      [15:0]      cfgRdData,
  // socket present state
  output cdvs_present_type      presentState
);
  initial
  begin
    if (SETTLE_CYCLES < `CDVS_SYNC_LAT || SETTLE_CYCLES > 65535)
      $error("cdvs_top: SETTLE_CYCLES out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_PROBE_OPEN, ST_PROBE_CD1, ST_PROBE_CD2,
                            ST_DONE} cdvs_state_type;

  logic [3:0] pinClean;
  logic       cd1Clean;
  logic       cd2Clean;
  logic       vs1Clean;
  logic       vs2Clean;

  cdvs_pin_sync #(
    .WIDTH     (4)
  ) u_sync (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .pinIn     ({vs2In, vs1In, cd2In, cd1In}),
    .pinStable (pinClean)
  );

  assign cd1Clean = pinClean[0];
  assign cd2Clean = pinClean[1];
  assign vs1Clean = pinClean[2];
  assign vs2Clean = pinClean[3];

  // sense line wiring from its level in the three probe phases
  function automatic cdvs_sense_type sense_code(input logic lvlOpen, input logic lvlCd1,
                                                input logic lvlCd2);
    if (!lvlOpen)
      sense_code = SENSE_GND;
    else if (!lvlCd1)
      sense_code = SENSE_CD1;
    else if (!lvlCd2)
      sense_code = SENSE_CD2;
    else
      sense_code = SENSE_OPEN;
  endfunction

  function automatic cdvs_class_type classify(input cdvs_wiring_type w);
    cdvs_class_type c;
    c = '{kind: CARD_RESERVED, default: 1'b0};
    if (w.cd1Gnd && w.cd2Gnd)
    begin
      c.kind = CARD_16BIT;
      case ({w.vs2, w.vs1})
        {SENSE_OPEN, SENSE_OPEN}: c.needs5v = 1'b1;
        {SENSE_OPEN, SENSE_GND}:  {c.needs5v, c.needs3v} = 2'h3;
        {SENSE_GND, SENSE_GND}:   {c.needs5v, c.needs3v, c.needsXv} = 3'h7;
        {SENSE_GND, SENSE_OPEN}:  c.needsXv = 1'b1;
        default:                  c.kind = CARD_RESERVED;
      endcase
    end
    else if (w.cd2Gnd && !w.cd1Gnd)
    begin
      c.kind = CARD_CARDBUS;
      case ({w.vs2, w.vs1})
        {SENSE_OPEN, SENSE_CD1}: c.needs3v = 1'b1;
        {SENSE_CD1, SENSE_OPEN}: {c.needsXv, c.needsYv} = 2'h3;
        {SENSE_GND, SENSE_CD1}:  c.kind = CARD_CUSTOM;
        default:                 c.kind = CARD_RESERVED;
      endcase
    end
    else if (w.cd1Gnd && !w.cd2Gnd)
    begin
      c.kind = CARD_CARDBUS;
      case ({w.vs2, w.vs1})
        {SENSE_CD2, SENSE_GND}:  {c.needs3v, c.needsXv} = 2'h3;
        {SENSE_GND, SENSE_CD2}:  {c.needs3v, c.needsXv, c.needsYv} = 3'h7;
        {SENSE_CD2, SENSE_OPEN}: {c.needs3v, c.core18} = 2'h3;
        {SENSE_OPEN, SENSE_CD2}: c.needsYv = 1'b1;
        default:                 c.kind = CARD_RESERVED;
      endcase
    end
    classify = c;
  endfunction

  cdvs_state_type   state_reg;
  cdvs_state_type   state_next;
  logic [15:0]      timer_reg;
  logic [15:0]      timer_next;
  logic [3:0]       probeOpen_reg;
  logic [3:0]       probeOpen_next;
  logic [1:0]       probeCd1_reg;
  logic [1:0]       probeCd1_next;
  cdvs_class_type   class_reg;
  cdvs_class_type   class_next;
  logic             cd1OeB_reg;
  logic             cd1OeB_next;
  logic             cd2OeB_reg;
  logic             cd2OeB_next;
  logic [15:0]      genCtrl_reg;
  logic [15:0]      genCtrl_next;
  logic [15:0]      rdData_reg;
  logic [15:0]      rdData_next;
  cdvs_present_type present_reg;
  cdvs_present_type present_next;
  cdvs_wiring_type  wiring;
  logic             anyDetect;
  logic             timerDone;
  logic             switchSel;

  assign anyDetect = !cd1Clean || !cd2Clean;
  assign timerDone = (timer_reg == 16'h0000);
  assign switchSel = genCtrl_reg[`CDVS_PSWSEL_BIT];

  // final phase: detect2 driven, sense levels taken directly
  always_comb
  begin
    wiring.cd1Gnd = !probeOpen_reg[0];
    wiring.cd2Gnd = !probeOpen_reg[1];
    wiring.vs1    = sense_code(probeOpen_reg[2], probeCd1_reg[0], vs1Clean);
    wiring.vs2    = sense_code(probeOpen_reg[3], probeCd1_reg[1], vs2Clean);
  end

  always_comb
  begin
    state_next     = state_reg;
    timer_next     = timerDone ? 16'h0000 : timer_reg - 16'h0001;
    probeOpen_next = probeOpen_reg;
    probeCd1_next  = probeCd1_reg;
    class_next     = class_reg;
    cd1OeB_next    = 1'b1;
    cd2OeB_next    = 1'b1;
    case (state_reg)
      ST_IDLE:
      begin
        class_next = '{kind: CARD_NONE, default: 1'b0};
        if (anyDetect && !socketPowered)
        begin
          state_next = ST_PROBE_OPEN;
          timer_next = 16'(SETTLE_CYCLES);
        end
      end
      ST_PROBE_OPEN:
      begin
        if (!anyDetect)
          state_next = ST_IDLE;
        else if (timerDone)
        begin
          probeOpen_next = {vs2Clean, vs1Clean, cd2Clean, cd1Clean};
          state_next     = ST_PROBE_CD1;
          timer_next     = 16'(SETTLE_CYCLES);
          cd1OeB_next    = 1'b0;
        end
      end
      ST_PROBE_CD1:
      begin
        cd1OeB_next = 1'b0;
        if (timerDone)
        begin
          probeCd1_next = {vs2Clean, vs1Clean};
          state_next    = ST_PROBE_CD2;
          timer_next    = 16'(SETTLE_CYCLES);
          cd1OeB_next   = 1'b1;
          cd2OeB_next   = 1'b0;
        end
      end
      ST_PROBE_CD2:
      begin
        cd2OeB_next = 1'b0;
        if (timerDone)
        begin
          class_next  = classify(wiring);
          state_next  = ST_DONE;
          cd2OeB_next = 1'b1;
        end
      end
      ST_DONE:
      begin
        if (cd1Clean && cd2Clean)
          state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_comb
  begin
    genCtrl_next = genCtrl_reg;
    if (cfgWrEn && cfgAddr == `CDVS_GENCTRL_OFFSET)
      genCtrl_next = cfgWrData;
    rdData_next = (cfgAddr == `CDVS_GENCTRL_OFFSET) ? genCtrl_reg : 16'h0000;
  end

  always_comb
  begin
    present_next                  = '0;
    present_next.cardPresent      = (state_reg == ST_DONE);
    present_next.interrogating    = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
    present_next.kind             = (state_reg == ST_DONE) ? class_reg.kind : CARD_NONE;
    if (state_reg == ST_DONE)
    begin
      present_next.fiveVoltCardFlag = class_reg.needs5v;
      present_next.yVoltCardFlag    = class_reg.needsYv;
      present_next.core18Card       = class_reg.core18;
      present_next.lowVoltCardFlag  = class_reg.needs3v && !(class_reg.core18 && switchSel);
      present_next.altVoltCardFlag  = class_reg.needsXv || (class_reg.core18 && switchSel);
      present_next.powerAllowed     = (class_reg.kind != CARD_RESERVED);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_reg     <= ST_IDLE;
      timer_reg     <= 16'h0000;
      probeOpen_reg <= 4'hf;
      probeCd1_reg  <= 2'h3;
      class_reg     <= '{kind: CARD_NONE, default: 1'b0};
      cd1OeB_reg    <= 1'b1;
      cd2OeB_reg    <= 1'b1;
      genCtrl_reg   <= `CDVS_GENCTRL_RESET;
      rdData_reg    <= 16'h0000;
      present_reg   <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      timer_reg     <= timer_next;
      probeOpen_reg <= probeOpen_next;
      probeCd1_reg  <= probeCd1_next;
      class_reg     <= class_next;
      cd1OeB_reg    <= cd1OeB_next;
      cd2OeB_reg    <= cd2OeB_next;
      genCtrl_reg   <= genCtrl_next;
      rdData_reg    <= rdData_next;
      present_reg   <= present_next;
    end
  end

  // detect lines are only ever pulled low
  logic cdLow_reg;
  always_ff @(posedge mclk)
  begin
    cdLow_reg <= 1'b0;
  end

  assign cd1Out       = cdLow_reg;
  assign cd2Out       = cdLow_reg;
  assign cd1OeB       = cd1OeB_reg;
  assign cd2OeB       = cd2OeB_reg;
  assign cfgRdData    = rdData_reg;
  assign presentState = present_reg;
endmodule
`default_nettype wire

// ---- sim/cdvs_monitor.sv ----
// port checker for the card detect and voltage sense block
`timescale 1ns/1ps
`default_nettype none
`include "cdvs_defines.svh"
module cdvs_monitor
  import cdvs_pkg::*;
#(
  parameter int SETTLE_CYCLES = 4
)
(
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst_b,
  // detect pin drive
  input wire logic             cd1Out,
  input wire logic             cd1OeB,
  input wire logic             cd2Out,
  input wire logic             cd2OeB,
  input wire logic             socketPowered,
  // configuration access
  input wire logic [7:0]       cfgAddr,
  input wire logic             cfgWrEn,
  input wire logic [15:0]      cfgWrData,
  input wire logic [15:0]      cfgRdData,
  input wire cdvs_present_type presentState
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [15:0] genMirror;
  logic [7:0]  low1Cnt;
  logic [7:0]  low2Cnt;
  logic        sel;
  assign sel = genMirror[`CDVS_PSWSEL_BIT];
  // mirror of the control register and lengths of each drive phase
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      genMirror <= `CDVS_GENCTRL_RESET;
      low1Cnt <= 8'h00;
      low2Cnt <= 8'h00;
    end
    else
    begin
      if (cfgWrEn && cfgAddr == `CDVS_GENCTRL_OFFSET)
        genMirror <= cfgWrData;
      low1Cnt <= cd1OeB ? 8'h00 : low1Cnt + 8'h01;
      low2Cnt <= cd2OeB ? 8'h00 : low2Cnt + 8'h01;
    end
  end
  sequence held_powered;
    (socketPowered && !presentState.interrogating) [*3];
  endsequence
  rst_release_a: assert property ($rose(rst_b) |-> cd1OeB && cd2OeB)
    else $error("detect drive on after reset");
  one_drive_a: assert property (cd1OeB || cd2OeB)
    else $error("both detect lines driven");
  drive_low_a: assert property (cd1Out == 1'b0 && cd2Out == 1'b0)
    else $error("detect drive value not low");
  phase_one_a: assert property ($rose(cd1OeB) && $past(rst_b) |->
    int'(low1Cnt) == SETTLE_CYCLES + 1 && !cd2OeB) else $error("first drive phase length");
  phase_two_a: assert property ($rose(cd2OeB) && $past(rst_b) |->
    int'(low2Cnt) == SETTLE_CYCLES + 1) else $error("second drive phase length");
  powered_idle_a: assert property (held_powered |=> !presentState.interrogating)
    else $error("probe started on powered socket");
  probe_unpow_a: assert property (presentState.interrogating |-> !presentState.powerAllowed)
    else $error("power allowed during probe");
  rsvd_unpow_a: assert property (presentState.kind == CARD_RESERVED |->
    !presentState.powerAllowed) else $error("reserved card allowed power");
  cfg_read_a: assert property (cfgRdData == ($past(cfgAddr) == `CDVS_GENCTRL_OFFSET ?
    $past(genMirror) : 16'h0000)) else $error("config read data wrong");
  flag_sel_a: assert property (presentState.core18Card && sel == $past(sel) &&
    sel == $past(sel, 2) |-> presentState.altVoltCardFlag == sel &&
    presentState.lowVoltCardFlag == !sel && presentState.kind == CARD_CARDBUS)
    else $error("low voltage card flag choice wrong");
endmodule
`default_nettype wire

// ---- sim/cdvs_card_model.sv ----
// model of the inserted card's detect and sense wiring, lines pulled up
`timescale 1ns/1ps
`default_nettype none
module cdvs_card_model
  import cdvs_pkg::*;
(
  // card state from the bench
  input  wire logic            inserted,
  input  wire cdvs_wiring_type wiring,
  // socket side
  input  wire logic            cd1Out,
  input  wire logic            cd1OeB,
  input  wire logic            cd2Out,
  input  wire logic            cd2OeB,
  output logic                 cd1In,
  output logic                 cd2In,
  output logic                 vs1In,
  output logic                 vs2In
);
  logic drive1;
  logic drive2;
  function automatic logic pulled(cdvs_sense_type s, logic d1, logic d2);
    return s == SENSE_GND || (s == SENSE_CD1 && d1) || (s == SENSE_CD2 && d2);
  endfunction
  always_comb
  begin
    drive1 = !cd1OeB && !cd1Out;
    drive2 = !cd2OeB && !cd2Out;
    cd1In = !(inserted && wiring.cd1Gnd) && !drive1;
    cd2In = !(inserted && wiring.cd2Gnd) && !drive2;
    vs1In = !(inserted && pulled(wiring.vs1, drive1, drive2));
    vs2In = !(inserted && pulled(wiring.vs2, drive1, drive2));
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the card detect and voltage sense block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cdvs_pkg::*;
;
  localparam int SETTLE = 4;
  logic             mclk, rst_b, socketPowered, cfgWrEn, inserted;
  logic             cd1In, cd2In, vs1In, vs2In, cd1Out, cd1OeB, cd2Out, cd2OeB;
  logic [7:0]       cfgAddr;
  logic [15:0]      cfgWrData, cfgRdData;
  cdvs_present_type presentState;
  cdvs_wiring_type  wiring;
  int               fail_count, n_tests, cyc;
  cdvs_top #(.SETTLE_CYCLES(SETTLE)) DUT (.mclk, .rst_b, .cd1In, .cd2In, .vs1In, .vs2In,
    .cd1Out, .cd1OeB, .cd2Out, .cd2OeB, .socketPowered, .cfgAddr, .cfgWrEn, .cfgWrData,
    .cfgRdData, .presentState);
  cdvs_card_model card (.inserted, .wiring, .cd1Out, .cd1OeB, .cd2Out, .cd2OeB,
    .cd1In, .cd2In, .vs1In, .vs2In);
  initial mclk = 1'b0;
  always #50 mclk = !mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] stat();
    return {6'h00, presentState.fiveVoltCardFlag, presentState.yVoltCardFlag,
      presentState.core18Card, presentState.kind, presentState.lowVoltCardFlag,
      presentState.altVoltCardFlag, presentState.powerAllowed, presentState.cardPresent};
  endfunction
  function automatic logic [15:0] want(cdvs_card_type k, logic l, logic a, logic p,
    logic [2:0] fyc = 3'h0);
    return {6'h00, fyc, k, l, a, p, 1'b1};
  endfunction
  task automatic cfg(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge mclk);
    cfgAddr <= a;
    cfgWrEn <= w;
    cfgWrData <= d;
    @(posedge mclk);
    cfgWrEn <= 1'b0;
    #1;
  endtask
  task automatic wait_present(input logic v);
    for (int n = 0; n < 200 && presentState.cardPresent !== v; n++)
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic insert(input cdvs_wiring_type w);
    @(posedge mclk);
    wiring <= w;
    inserted <= 1'b1;
    wait_present(1'b1);
  endtask
  task automatic remove();
    @(posedge mclk);
    inserted <= 1'b0;
    wait_present(1'b0);
    chk(stat(), 16'h0000);
    repeat (8) @(posedge mclk);
  endtask
  task automatic t_regs();
    cfg(8'h86, 1'b0, 16'h0000);
    chk(cfgRdData, 16'h0000);
    cfg(8'h86, 1'b1, 16'hffff);
    cfg(8'h84, 1'b1, 16'h1234);
    cfg(8'h86, 1'b0, 16'h0000);
    chk(cfgRdData, 16'hffff);
    cfg(8'h84, 1'b0, 16'h0000);
    chk(cfgRdData, 16'h0000);
    cfg(8'h86, 1'b1, 16'h0000);
    $display("register test done");
  endtask
  task automatic t_table();
    cdvs_wiring_type w[6];
    logic [15:0]     e[6];
    w = '{'{1'b1, 1'b1, SENSE_OPEN, SENSE_OPEN}, '{1'b1, 1'b0, SENSE_OPEN, SENSE_CD1},
      '{1'b1, 1'b0, SENSE_GND, SENSE_CD1}, '{1'b1, 1'b0, SENSE_CD1, SENSE_GND},
      '{1'b1, 1'b1, SENSE_GND, SENSE_OPEN}, '{1'b0, 1'b1, SENSE_OPEN, SENSE_CD2}};
    e = '{want(CARD_16BIT, 1'b0, 1'b0, 1'b1, 3'h4), want(CARD_CARDBUS, 1'b1, 1'b0, 1'b1),
      want(CARD_CUSTOM, 1'b0, 1'b0, 1'b1), want(CARD_RESERVED, 1'b0, 1'b0, 1'b0),
      want(CARD_16BIT, 1'b0, 1'b1, 1'b1), want(CARD_CARDBUS, 1'b0, 1'b0, 1'b1, 3'h2)};
    for (int i = 0; i < 6; i++)
    begin
      insert(w[i]);
      chk(stat(), e[i]);
      remove();
    end
    $display("pattern table test done");
  endtask
  task automatic t_low_volt();
    insert('{1'b0, 1'b1, SENSE_CD2, SENSE_OPEN});
    chk(stat(), want(CARD_CARDBUS, 1'b1, 1'b0, 1'b1, 3'h1));
    cfg(8'h86, 1'b1, 16'h0400);
    repeat (3) @(posedge mclk);
    #1;
    chk(stat(), want(CARD_CARDBUS, 1'b0, 1'b1, 1'b1, 3'h1));
    remove();
    insert('{1'b0, 1'b1, SENSE_CD2, SENSE_OPEN});
    chk(stat(), want(CARD_CARDBUS, 1'b0, 1'b1, 1'b1, 3'h1));
    remove();
    cfg(8'h86, 1'b1, 16'h0000);
    $display("low voltage card test done");
  endtask
  task automatic t_powered();
    @(posedge mclk);
    socketPowered <= 1'b1;
    wiring <= '{1'b1, 1'b1, SENSE_OPEN, SENSE_OPEN};
    inserted <= 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    chk(stat(), 16'h0000);
    remove();
    socketPowered <= 1'b0;
    $display("powered socket test done");
  endtask
  initial
  begin
    rst_b = 1'b0;
    socketPowered = 1'b0;
    cfgWrEn = 1'b0;
    cfgAddr = 8'h00;
    cfgWrData = 16'h0000;
    inserted = 1'b0;
    wiring = '0;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_table();
    t_low_volt();
    t_powered();
    wrap_up();
  end
endmodule
bind cdvs_top cdvs_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) mon (.mclk, .rst_b, .cd1Out,
  .cd1OeB, .cd2Out, .cd2OeB, .socketPowered, .cfgAddr, .cfgWrEn, .cfgWrData, .cfgRdData,
  .presentState);
`default_nettype wire
